// File: src/codec_regs.sv
// Purpose: APB register bank for ADC rate, digital output, equalizer, mixer and jack sense
// Assumes: Single clock pclk at 250 MHz, jack and error inputs synchronous to pclk
// Notes: Zero-wait APB slave; read data captured in the setup cycle
// Operation
// - ADC rate holds 1B58h..BB80h in hertz
// - Writing variable rate off restores 48 kHz
// - Four status flags go to channel status
// - Category code and generation level passed through
// - Rate select encoding, register resets 2000h
// - Validity bit one forces invalid flag
// - Validity bit zero follows error detection
// - Override forces flag low when bit zero
// - Equalizer control resets to 8080h
// - Pointer addresses biquad coefficients 25..59
// - Side select picks left or right block
// - Mirror makes right fetch from left
// - Loopback adds mixer ADC into PCM
// - Bypass passes data, resets to one
// - Data port reads and writes pointed word
// - Coefficient writes commit only during bypass
// - Coefficients are 16-bit, port resets 0000h
// - Four-bit gains in 1.5 dB steps
// - Mute-all mutes both, resets 8000h
// - Right mute works only with split enabled
// - Timer needs jack high over 250 ms
// - Jack flags sticky, write one sets
`timescale 1ns/1ps
`default_nettype none

module codec_regs #(
    parameter int JACK_TIMER_CYCLES = codec_regs_pkg::JACK_TIMER_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [15:0] rate_value,
    output logic variable_rate_enable,
    output logic transmit_enable,
    output codec_regs_pkg::chan_status_t chan_status,
    input wire logic [1:0] sample_error,
    output logic [1:0] validity_flag,
    output logic filter_bypass,
    output logic mixer_loopback,
    input wire logic coef_fetch_side,
    input wire logic [5:0] coef_fetch_addr,
    output logic [15:0] coef_fetch_data,
    output codec_regs_pkg::mixer_ctrl_t mixer_ctrl,
    input wire logic [1:0] jack_sense,
    output logic [2:0] jack_mute_select,
    output logic jack_irq
);
    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] ext;
        logic [15:0] rate;
        logic [15:0] dout;
        logic [15:0] eqc;
        logic [15:0] mix;
        logic [15:0] jack;
        logic [15:0] misc;
        logic [1:0][codec_regs_pkg::JACK_CNT_W-1:0] jcnt;
        logic [1:0] jprev;
        logic [31:0] rdata;
        logic rerr;
        logic [1:0] valid;
        logic [15:0] fetch;
        logic [1:0][63:0][15:0] mem;
    } state_t;

    localparam logic [codec_regs_pkg::JACK_CNT_W-1:0] JCNT_MAX = JACK_TIMER_CYCLES[codec_regs_pkg::JACK_CNT_W-1:0];

    state_t cur_ff;
    state_t nxt_cur;
    logic access;
    logic wr;
    logic [7:0] idx;
    logic aligned;
    logic [15:0] wdata;
    logic [5:0] ptr;
    logic side;
    logic [1:0] jack_state;
    logic [1:0] jack_event;

    function automatic logic coef_in_range(input logic [5:0] a);
        coef_in_range = (a >= codec_regs_pkg::COEF_FIRST) && (a <= codec_regs_pkg::COEF_LAST);
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] val, input logic [15:0] mask);
        merge = (old & ~mask) | (val & mask);
    endfunction

    assign access = psel && penable;
    assign wr = access && pwrite && aligned;
    assign idx = paddr[9:2];
    assign aligned = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
    assign wdata = pwdata[15:0];
    assign ptr = cur_ff.eqc[5:0];
    assign side = cur_ff.eqc[codec_regs_pkg::EQ_SIDE_BIT];

    // -----------------------------------------------------------------
    // Jack sense qualification
    // -----------------------------------------------------------------
    // With the timer on, a pin is seen only after staying high past the count
    always_comb
    begin
        for (int j = 0; j < 2; j++)
        begin
            if (cur_ff.jack[6 + j])
            begin
                jack_state[j] = jack_sense[j] && (cur_ff.jcnt[j] == JCNT_MAX);
            end
            else
            begin
                jack_state[j] = jack_sense[j];
            end
            jack_event[j] = cur_ff.jack[4 + j] && jack_state[j] && !cur_ff.jprev[j];
        end
    end

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb
    begin
        nxt_cur = cur_ff;
        for (int j = 0; j < 2; j++)
        begin
            if (!jack_sense[j])
            begin
                nxt_cur.jcnt[j] = '0;
            end
            else if (cur_ff.jcnt[j] != JCNT_MAX)
            begin
                nxt_cur.jcnt[j] = cur_ff.jcnt[j] + 1'b1;
            end
        end
        nxt_cur.jprev = jack_state;

        // Validity flag per subframe, left in bit 0
        if (cur_ff.dout[codec_regs_pkg::DOUT_V_BIT])
        begin
            nxt_cur.valid = 2'b11;
        end
        else if (cur_ff.ext[codec_regs_pkg::EXT_VOVR_BIT])
        begin
            nxt_cur.valid = 2'b00;
        end
        else
        begin
            nxt_cur.valid = sample_error;
        end

        // Mirror steers right-side fetches into the left block
        if (cur_ff.eqc[codec_regs_pkg::EQ_SYM_BIT])
        begin
            nxt_cur.fetch = cur_ff.mem[0][coef_fetch_addr];
        end
        else
        begin
            nxt_cur.fetch = cur_ff.mem[coef_fetch_side][coef_fetch_addr];
        end

        if (wr)
        begin
            case (idx)
                codec_regs_pkg::IDX_EXT_CTRL:
                begin
                    nxt_cur.ext = merge(cur_ff.ext, wdata, codec_regs_pkg::EXT_MASK);
                    if (!wdata[codec_regs_pkg::EXT_VRA_BIT])
                    begin
                        nxt_cur.rate = codec_regs_pkg::RATE_MAX;
                    end
                end
                codec_regs_pkg::IDX_ADC_RATE:
                begin
                    // Out-of-range rates are dropped so the stored rate stays usable
                    if (wdata >= codec_regs_pkg::RATE_MIN && wdata <= codec_regs_pkg::RATE_MAX)
                    begin
                        nxt_cur.rate = wdata;
                    end
                end
                codec_regs_pkg::IDX_DOUT:
                begin
                    nxt_cur.dout = merge(cur_ff.dout, wdata, codec_regs_pkg::DOUT_MASK);
                end
                codec_regs_pkg::IDX_EQ_CTRL:
                begin
                    nxt_cur.eqc = merge(cur_ff.eqc, wdata, codec_regs_pkg::EQ_MASK);
                end
                codec_regs_pkg::IDX_EQUALIZER_COEF_PORT:
                begin
                    if (cur_ff.eqc[codec_regs_pkg::EQ_BYPASS_BIT] && coef_in_range(ptr))
                    begin
                        nxt_cur.mem[side][ptr] = wdata;
                    end
                end
                codec_regs_pkg::IDX_MIX:
                begin
                    nxt_cur.mix = merge(cur_ff.mix, wdata, codec_regs_pkg::MIX_MASK);
                    if (!cur_ff.misc[codec_regs_pkg::MISC_SPLIT_BIT])
                    begin
                        nxt_cur.mix[codec_regs_pkg::MIX_RMUTE_BIT] = 1'b0;
                    end
                end
                codec_regs_pkg::IDX_JACK:
                begin
                    nxt_cur.jack = merge(cur_ff.jack, wdata, codec_regs_pkg::JACK_MASK);
                end
                codec_regs_pkg::IDX_MISC:
                begin
                    nxt_cur.misc = merge(cur_ff.misc, wdata, codec_regs_pkg::MISC_MASK);
                end
                default:
                begin
                end
            endcase
        end
        // Split off drops any held right mute so it can neither act nor read back
        if (!nxt_cur.misc[codec_regs_pkg::MISC_SPLIT_BIT])
        begin
            nxt_cur.mix[codec_regs_pkg::MIX_RMUTE_BIT] = 1'b0;
        end
        // A jack event landing with a clearing write still sets its flag
        nxt_cur.jack[1:0] = nxt_cur.jack[1:0] | jack_event;

        // Read data is captured in the setup cycle for a zero-wait access
        if (psel && !penable)
        begin
            nxt_cur.rdata = '0;
            nxt_cur.rerr = 1'b0;
            if (!aligned)
            begin
                nxt_cur.rerr = 1'b1;
            end
            else
            begin
                case (idx)
                    codec_regs_pkg::IDX_EXT_CTRL:
                    begin
                        nxt_cur.rdata[15:0] = cur_ff.ext;
                    end
                    codec_regs_pkg::IDX_ADC_RATE:
                    begin
                        nxt_cur.rdata[15:0] = cur_ff.rate;
                    end
                    codec_regs_pkg::IDX_DOUT:
                    begin
                        nxt_cur.rdata[15:0] = cur_ff.dout;
                    end
                    codec_regs_pkg::IDX_EQ_CTRL:
                    begin
                        nxt_cur.rdata[15:0] = cur_ff.eqc;
                    end
                    codec_regs_pkg::IDX_EQUALIZER_COEF_PORT:
                    begin
                        if (coef_in_range(ptr))
                        begin
                            nxt_cur.rdata[15:0] = cur_ff.mem[side][ptr];
                        end
                    end
                    codec_regs_pkg::IDX_MIX:
                    begin
                        nxt_cur.rdata[15:0] = cur_ff.mix;
                    end
                    codec_regs_pkg::IDX_JACK:
                    begin
                        nxt_cur.rdata[15:0] = {cur_ff.jack[15:4], jack_sense, cur_ff.jack[1:0]};
                    end
                    codec_regs_pkg::IDX_MISC:
                    begin
                        nxt_cur.rdata[15:0] = cur_ff.misc;
                    end
                    default:
                    begin
                        nxt_cur.rerr = 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur_ff <= '0;
            cur_ff.ext <= codec_regs_pkg::EXT_RST;
            cur_ff.rate <= codec_regs_pkg::RATE_RST;
            cur_ff.dout <= codec_regs_pkg::DOUT_RST;
            cur_ff.eqc <= codec_regs_pkg::EQ_RST;
            cur_ff.mix <= codec_regs_pkg::MIX_RST;
            cur_ff.jack <= codec_regs_pkg::JACK_RST;
            cur_ff.misc <= codec_regs_pkg::MISC_RST;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign pready = access;
    assign pslverr = access && cur_ff.rerr;
    assign prdata = cur_ff.rdata;
    assign rate_value = cur_ff.rate;
    assign variable_rate_enable = cur_ff.ext[codec_regs_pkg::EXT_VRA_BIT];
    // Channel status only changes cleanly while this is low
    assign transmit_enable = cur_ff.ext[codec_regs_pkg::EXT_TXEN_BIT];
    assign chan_status.usage_class_flag = cur_ff.dout[0];
    assign chan_status.nonpcm_flag = cur_ff.dout[1];
    assign chan_status.copyright_flag = cur_ff.dout[2];
    assign chan_status.emphasis_flag = cur_ff.dout[3];
    assign chan_status.category_code = cur_ff.dout[10:4];
    assign chan_status.generation_level = cur_ff.dout[11];
    assign chan_status.spdif_rate_select = cur_ff.dout[13:12];
    assign validity_flag = cur_ff.valid;
    // A qualified jack with its bypass enable also bypasses the filter
    assign filter_bypass = cur_ff.eqc[codec_regs_pkg::EQ_BYPASS_BIT] || |(cur_ff.jack[9:8] & jack_state);
    assign mixer_loopback = cur_ff.eqc[codec_regs_pkg::EQ_LOOP_BIT];
    assign coef_fetch_data = cur_ff.fetch;
    assign mixer_ctrl.left_gain = cur_ff.mix[11:8];
    assign mixer_ctrl.right_gain = cur_ff.mix[3:0];
    assign mixer_ctrl.left_mute = cur_ff.mix[codec_regs_pkg::MIX_MUTE_BIT];
    assign mixer_ctrl.right_mute = cur_ff.mix[codec_regs_pkg::MIX_MUTE_BIT] || cur_ff.mix[codec_regs_pkg::MIX_RMUTE_BIT];
    assign jack_mute_select = cur_ff.jack[12:10];
    assign jack_irq = |cur_ff.jack[1:0];

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_vra_off_write;
        wr && idx == codec_regs_pkg::IDX_EXT_CTRL && !wdata[codec_regs_pkg::EXT_VRA_BIT];
    endsequence

    property p_vra_rate;
        s_vra_off_write |=> rate_value == codec_regs_pkg::RATE_MAX;
    endproperty
    a_vra_rate: assert property (p_vra_rate) else $error("rate not restored to 48 kHz");

    property p_rate_range;
        rate_value >= codec_regs_pkg::RATE_MIN && rate_value <= codec_regs_pkg::RATE_MAX;
    endproperty
    a_rate_range: assert property (p_rate_range) else $error("rate outside legal range");

    property p_valid_force;
        cur_ff.dout[codec_regs_pkg::DOUT_V_BIT] |=> validity_flag == 2'b11;
    endproperty
    a_valid_force: assert property (p_valid_force) else $error("validity not forced high");

    property p_valid_err;
        !cur_ff.dout[codec_regs_pkg::DOUT_V_BIT] && !cur_ff.ext[codec_regs_pkg::EXT_VOVR_BIT]
            |=> validity_flag == $past(sample_error);
    endproperty
    a_valid_err: assert property (p_valid_err) else $error("validity does not follow errors");

    property p_valid_ovr;
        !cur_ff.dout[codec_regs_pkg::DOUT_V_BIT] && cur_ff.ext[codec_regs_pkg::EXT_VOVR_BIT] |=> validity_flag == 2'b00;
    endproperty
    a_valid_ovr: assert property (p_valid_ovr) else $error("override did not clear validity");

    sequence s_coef_write;
        wr && idx == codec_regs_pkg::IDX_EQUALIZER_COEF_PORT;
    endsequence

    property p_coef_gate;
        s_coef_write and !cur_ff.eqc[codec_regs_pkg::EQ_BYPASS_BIT] |=> $stable(cur_ff.mem);
    endproperty
    a_coef_gate: assert property (p_coef_gate) else $error("coefficient stored outside bypass");

    property p_coef_store;
        s_coef_write and cur_ff.eqc[codec_regs_pkg::EQ_BYPASS_BIT] and coef_in_range(ptr)
            |=> cur_ff.mem[$past(side)][$past(ptr)] == $past(wdata);
    endproperty
    a_coef_store: assert property (p_coef_store) else $error("coefficient not stored");

    property p_rmute_split;
        !cur_ff.misc[codec_regs_pkg::MISC_SPLIT_BIT] |-> !cur_ff.mix[codec_regs_pkg::MIX_RMUTE_BIT];
    endproperty
    a_rmute_split: assert property (p_rmute_split) else $error("right mute held without split");

    property p_mute_all;
        cur_ff.mix[codec_regs_pkg::MIX_MUTE_BIT] |-> mixer_ctrl.left_mute && mixer_ctrl.right_mute;
    endproperty
    a_mute_all: assert property (p_mute_all) else $error("mute all left a channel open");

    property p_jack_sticky;
        jack_irq && !(wr && idx == codec_regs_pkg::IDX_JACK) |=> jack_irq;
    endproperty
    a_jack_sticky: assert property (p_jack_sticky) else $error("jack flag dropped without write");
endmodule

`default_nettype wire

// File: src/codec_regs_pkg.sv
// Purpose: Shared constants and types for the codec control register bank
// Assumes: APB word access, 16-bit registers in the low half of each word
// Notes: Printed offsets are register indices; byte address is index times four
package codec_regs_pkg;
    // -----------------------------------------------------------------
    // Register indices
    // -----------------------------------------------------------------
    localparam logic [7:0] IDX_EXT_CTRL = 8'h2A;
    localparam logic [7:0] IDX_ADC_RATE = 8'h32;
    localparam logic [7:0] IDX_DOUT = 8'h3A;
    localparam logic [7:0] IDX_EQ_CTRL = 8'h60;
    localparam logic [7:0] IDX_EQUALIZER_COEF_PORT = 8'h62;
    localparam logic [7:0] IDX_MIX = 8'h64;
    localparam logic [7:0] IDX_JACK = 8'h72;
    localparam logic [7:0] IDX_MISC = 8'h76;
    // -----------------------------------------------------------------
    // Reset values and writable masks
    // -----------------------------------------------------------------
    localparam logic [15:0] EXT_RST = 16'h0000;
    localparam logic [15:0] RATE_RST = 16'hBB80;
    localparam logic [15:0] RATE_MIN = 16'h1B58;
    localparam logic [15:0] RATE_MAX = 16'hBB80;
    localparam logic [15:0] DOUT_RST = 16'h2000;
    localparam logic [15:0] EQ_RST = 16'h8080;
    localparam logic [15:0] MIX_RST = 16'h8000;
    localparam logic [15:0] JACK_RST = 16'h0000;
    localparam logic [15:0] MISC_RST = 16'h0000;
    localparam logic [15:0] EXT_MASK = 16'h8005;
    localparam logic [15:0] DOUT_MASK = 16'hBFFF;
    localparam logic [15:0] EQ_MASK = 16'hC0FF;
    localparam logic [15:0] MIX_MASK = 16'h8F8F;
    localparam logic [15:0] JACK_MASK = 16'h1FF3;
    localparam logic [15:0] MISC_MASK = 16'h2000;
    // -----------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------
    localparam int EXT_VRA_BIT = 0;
    localparam int EXT_TXEN_BIT = 2;
    localparam int EXT_VOVR_BIT = 15;
    localparam int DOUT_V_BIT = 15;
    localparam int EQ_BYPASS_BIT = 15;
    localparam int EQ_LOOP_BIT = 14;
    localparam int EQ_SYM_BIT = 7;
    localparam int EQ_SIDE_BIT = 6;
    localparam int MIX_MUTE_BIT = 15;
    localparam int MIX_RMUTE_BIT = 7;
    localparam int MISC_SPLIT_BIT = 13;
    localparam logic [5:0] COEF_FIRST = 6'h19;
    localparam logic [5:0] COEF_LAST = 6'h3B;
    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int PCLK_MHZ = 250;
    localparam int JACK_TIMER_MS = 250;
    localparam int JACK_TIMER_CYCLES = JACK_TIMER_MS * 1000 * PCLK_MHZ;
    localparam int JACK_CNT_W = 26;

    typedef struct packed {
        logic usage_class_flag;
        logic nonpcm_flag;
        logic copyright_flag;
        logic emphasis_flag;
        logic [6:0] category_code;
        logic generation_level;
        logic [1:0] spdif_rate_select;
    } chan_status_t;

    typedef struct packed {
        logic [3:0] left_gain;
        logic [3:0] right_gain;
        logic left_mute;
        logic right_mute;
    } mixer_ctrl_t;
endpackage

// File: tb/codec_host_model.sv
// Purpose: Link controller stand-in issuing APB register transfers
// Assumes: Slave may add wait states; request held until pready
// Notes: Waits are bounded; a hang raises timed_out
`timescale 1ns/1ps
`default_nettype none
module codec_host_model (
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic timed_out
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        timed_out = 1'b0;
    end
    // ---------------------------------------------------------------
    // One bus cycle; output control is only rewritten while idle
    // ---------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
                        output logic [15:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {16'h0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 64);
        rd = prdata[15:0];
        err = pslverr;
        timed_out <= (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: tb/test_codec_spdif_eq_mixer_regs.sv
// Purpose: Self-checking bench for the codec control register bank
// Assumes: Jack timer shortened to 8 cycles
// Notes: Expected values come from the register layout alone
`timescale 1ns/1ps
`default_nettype none
module test_codec_spdif_eq_mixer_regs;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, timed_out;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] rate_value, coef_fetch_data;
    logic variable_rate_enable, transmit_enable, filter_bypass, mixer_loopback, coef_fetch_side, jack_irq;
    logic [1:0] sample_error, validity_flag, jack_sense;
    logic [5:0] coef_fetch_addr;
    logic [2:0] jack_mute_select;
    codec_regs_pkg::chan_status_t chan_status;
    codec_regs_pkg::mixer_ctrl_t mixer_ctrl;
    int err_total = 0;
    int checks_done = 0;
    codec_regs #(.JACK_TIMER_CYCLES(8)) codec_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rate_value(rate_value),
        .variable_rate_enable(variable_rate_enable), .transmit_enable(transmit_enable),
        .chan_status(chan_status), .sample_error(sample_error), .validity_flag(validity_flag),
        .filter_bypass(filter_bypass), .mixer_loopback(mixer_loopback),
        .coef_fetch_side(coef_fetch_side), .coef_fetch_addr(coef_fetch_addr),
        .coef_fetch_data(coef_fetch_data), .mixer_ctrl(mixer_ctrl), .jack_sense(jack_sense),
        .jack_mute_select(jack_mute_select), .jack_irq(jack_irq));
    codec_host_model codec_host_model_inst (.pclk(pclk), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .timed_out(timed_out));
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        logic [15:0] r;
        logic e;
        codec_host_model_inst.xfer(1'b1, idx, d, r, e);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
        logic [15:0] r;
        logic e;
        codec_host_model_inst.xfer(1'b0, idx, 16'h0000, r, e);
        chk("read data", {16'h0000, exp}, {16'h0000, r});
        chk("slave error", 32'h0, {31'h0, e});
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge timed_out)
    begin
        err_total++;
        wrap_up();
    end
    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial
    begin
        logic [15:0] r;
        logic e;
        presetn = 1'b0;
        sample_error = 2'b00;
        jack_sense = 2'b00;
        coef_fetch_side = 1'b0;
        coef_fetch_addr = 6'h00;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(codec_regs_pkg::IDX_DOUT, 16'h2000);
        rd(codec_regs_pkg::IDX_EQ_CTRL, 16'h8080);
        rd(codec_regs_pkg::IDX_EQUALIZER_COEF_PORT, 16'h0000);
        rd(codec_regs_pkg::IDX_MIX, 16'h8000);
        rd(codec_regs_pkg::IDX_JACK, 16'h0000);
        chk("mixer ctrl", 32'h3, {22'h0, mixer_ctrl});
        codec_host_model_inst.xfer(1'b0, 8'h01, 16'h0000, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        $display("test reset done");
        wr(codec_regs_pkg::IDX_EXT_CTRL, 16'h0005);
        settle(0);
        chk("rate enables", 32'h3, {30'h0, transmit_enable, variable_rate_enable});
        wr(codec_regs_pkg::IDX_ADC_RATE, 16'h1B58);
        rd(codec_regs_pkg::IDX_ADC_RATE, 16'h1B58);
        wr(codec_regs_pkg::IDX_ADC_RATE, 16'h1B57);
        wr(codec_regs_pkg::IDX_ADC_RATE, 16'hBB81);
        rd(codec_regs_pkg::IDX_ADC_RATE, 16'h1B58);
        wr(codec_regs_pkg::IDX_EXT_CTRL, 16'h0000);
        rd(codec_regs_pkg::IDX_ADC_RATE, 16'hBB80);
        chk("rate port", 32'hBB80, {16'h0, rate_value});
        $display("test rate done");
        wr(codec_regs_pkg::IDX_DOUT, 16'h5ABD);
        rd(codec_regs_pkg::IDX_DOUT, 16'h1ABD);
        chk("status", {19'h0, 1'b1, 1'b0, 1'b1, 1'b1, 7'h2B, 1'b1, 2'b01}, {19'h0, chan_status});
        for (int i = 0; i < 4; i++)
        begin
            wr(codec_regs_pkg::IDX_DOUT, {2'b00, i[1:0], 12'h000});
            settle(0);
            chk("rate select", i, {30'h0, chan_status.spdif_rate_select});
        end
        wr(codec_regs_pkg::IDX_DOUT, 16'h8000);
        settle(2);
        chk("validity forced", 32'h3, {30'h0, validity_flag});
        wr(codec_regs_pkg::IDX_DOUT, 16'h0000);
        sample_error <= 2'b10;
        settle(3);
        chk("validity error", 32'h2, {30'h0, validity_flag});
        wr(codec_regs_pkg::IDX_EXT_CTRL, 16'h8000);
        settle(2);
        chk("validity override", 32'h0, {30'h0, validity_flag});
        $display("test digital out done");
        wr(codec_regs_pkg::IDX_EQ_CTRL, 16'h8019);
        wr(codec_regs_pkg::IDX_EQUALIZER_COEF_PORT, 16'h1234);
        wr(codec_regs_pkg::IDX_EQ_CTRL, 16'h8059);
        wr(codec_regs_pkg::IDX_EQUALIZER_COEF_PORT, 16'h5678);
        rd(codec_regs_pkg::IDX_EQUALIZER_COEF_PORT, 16'h5678);
        coef_fetch_addr <= 6'h19;
        coef_fetch_side <= 1'b1;
        settle(2);
        chk("right fetch", 32'h5678, {16'h0, coef_fetch_data});
        wr(codec_regs_pkg::IDX_EQ_CTRL, 16'h8099);
        settle(2);
        chk("mirrored fetch", 32'h1234, {16'h0, coef_fetch_data});
        wr(codec_regs_pkg::IDX_EQ_CTRL, 16'h4019);
        settle(0);
        chk("bypass and loop", 32'h1, {30'h0, filter_bypass, mixer_loopback});
        wr(codec_regs_pkg::IDX_EQUALIZER_COEF_PORT, 16'hAAAA);
        wr(codec_regs_pkg::IDX_EQ_CTRL, 16'h8019);
        rd(codec_regs_pkg::IDX_EQUALIZER_COEF_PORT, 16'h1234);
        chk("bypass on", 32'h1, {31'h0, filter_bypass});
        wr(codec_regs_pkg::IDX_EQ_CTRL, 16'h803B);
        wr(codec_regs_pkg::IDX_EQUALIZER_COEF_PORT, 16'h0BEE);
        rd(codec_regs_pkg::IDX_EQUALIZER_COEF_PORT, 16'h0BEE);
        wr(codec_regs_pkg::IDX_EQ_CTRL, 16'h803C);
        wr(codec_regs_pkg::IDX_EQUALIZER_COEF_PORT, 16'h1111);
        rd(codec_regs_pkg::IDX_EQUALIZER_COEF_PORT, 16'h0000);
        $display("test equalizer done");
        wr(codec_regs_pkg::IDX_MIX, 16'h7FFF);
        rd(codec_regs_pkg::IDX_MIX, 16'h0F0F);
        chk("gains", 32'h3FC, {22'h0, mixer_ctrl});
        wr(codec_regs_pkg::IDX_MISC, 16'h2000);
        wr(codec_regs_pkg::IDX_MIX, 16'h0A85);
        rd(codec_regs_pkg::IDX_MIX, 16'h0A85);
        chk("split mute", 32'h295, {22'h0, mixer_ctrl});
        $display("test mixer done");
        wr(codec_regs_pkg::IDX_JACK, 16'h1C01);
        settle(3);
        chk("mute select", 32'h7, {29'h0, jack_mute_select});
        chk("soft irq", 32'h1, {31'h0, jack_irq});
        wr(codec_regs_pkg::IDX_JACK, 16'h0050);
        jack_sense <= 2'b01;
        settle(4);
        chk("irq early", 32'h0, {31'h0, jack_irq});
        settle(16);
        chk("irq timed", 32'h1, {31'h0, jack_irq});
        rd(codec_regs_pkg::IDX_JACK, 16'h0055);
        wr(codec_regs_pkg::IDX_JACK, 16'h0050);
        settle(3);
        chk("irq cleared", 32'h0, {31'h0, jack_irq});
        $display("test jack done");
        wrap_up();
    end
endmodule
`default_nettype wire
